// >>> rtl/udb_dev.sv
`timescale 1ns/1ps
module udb_dev
    import udb_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    udb_if.dev                     bus,
    input  wire udb_mode_t         mode,
    input  wire logic              dir_in,
    input  wire logic              start,
    input  wire logic [DATA_W-1:0] tx_data,
    input  wire logic              tx_valid,
    output logic                   tx_ready,
    output logic [DATA_W-1:0]      rx_data,
    output logic                   rx_valid,
    input  wire logic              rx_pause,
    input  wire logic              crc_bad,
    output logic [7:0]             err_reg,
    output logic                   busy
);
    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_REQ  = 3'b001,
        D_ENV  = 3'b010,
        D_SEND = 3'b011,
        D_RECV = 3'b100,
        D_STOP = 3'b101,
        D_DONE = 3'b110
    } udb_dst_e;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] ack_s, stop_s, hstb_s, hrdy_s;
    logic       hstb_q;
    logic [DATA_W-1:0] dd_s1, dd_s2;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_s  <= 2'h3;
            stop_s <= 2'h0;
            hstb_s <= 2'h0;
            hrdy_s <= 2'h3;
            hstb_q <= 1'b0;
            dd_s1  <= '0;
            dd_s2  <= '0;
        end else begin
            ack_s  <= {ack_s[0], bus.dmack_n};
            stop_s <= {stop_s[0], bus.stop};
            hstb_s <= {hstb_s[0], bus.hstrobe};
            hrdy_s <= {hrdy_s[0], bus.hrdy_n};
            hstb_q <= hstb_s[1];
            dd_s1  <= bus.dd_h;
            dd_s2  <= dd_s1;
        end
    end
    wire ack_act  = !ack_s[1];
    wire stop_act = stop_s[1];
    wire hrdy_neg = hrdy_s[1];
    wire hstb_edge = hstb_s[1] ^ hstb_q;

    udb_dst_e          st_q;
    logic [CNT_W-1:0]  tmr_q;
    logic [CNT_W-1:0]  gap_q;
    logic              dir_q;
    logic              drive_q;
    logic              rdy_neg_q;
    logic [CNT_W-1:0]  rdy_tmr_q;
    udb_mode_t         mode_q;

    // ------------------------------------------------------------
    // Burst sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q     <= D_IDLE;
            tmr_q    <= '0;
            gap_q    <= '0;
            dir_q    <= 1'b0;
            mode_q   <= UDB_MODE0;
            drive_q  <= 1'b0;
            bus.dmarq    <= 1'b0;
            bus.dstrobe  <= 1'b0;
            bus.dd_d     <= '0;
            bus.dd_d_oe  <= 1'b0;
            tx_ready <= 1'b0;
            busy     <= 1'b0;
        end else begin
            tx_ready <= 1'b0;
            if (tmr_q != '0) tmr_q <= tmr_q - 1'b1;
            if (gap_q != '0) gap_q <= gap_q - 1'b1;
            case (st_q)
            D_IDLE: if (start) begin
                mode_q    <= (mode > UDB_MODE2) ? UDB_MODE2 : mode;
                dir_q     <= dir_in;
                bus.dmarq <= 1'b1;
                busy      <= 1'b1;
                st_q      <= D_REQ;
            end
            D_REQ: if (ack_act) begin
                tmr_q <= C_ENV;
                st_q  <= D_ENV;
            end
            D_ENV: if (tmr_q == '0) begin
                if (dir_q) begin
                    bus.dd_d_oe <= 1'b1;
                    bus.dd_d    <= tx_data;
                    // No word is taken here: each word leaves with a strobe
                    // First edge after one minimum interlock wait (C_MLI)
                    tmr_q <= C_MLI;
                    gap_q <= udb_max(T_FS_NS[udb_idx(mode_q)]);
                    st_q  <= D_SEND;
                end else st_q <= D_RECV;
            end
            D_SEND: begin
                if (stop_act) begin
                    tmr_q <= C_SS;
                    st_q  <= D_STOP;
                end else if (tmr_q == '0 && tx_valid && !hrdy_neg) begin
                    bus.dstrobe <= !bus.dstrobe;
                    bus.dd_d    <= tx_data;
                    tx_ready    <= 1'b1;
                    tmr_q <= udb_half(mode_q);
                end else if (tmr_q == '0 && !tx_valid) begin
                    tmr_q <= C_SS;
                    st_q  <= D_STOP;
                end
            end
            D_RECV: if (stop_act) begin
                tmr_q <= C_MLI;
                st_q  <= D_STOP;
            end
            D_STOP: if (tmr_q == '0) begin
                bus.dmarq   <= 1'b0;
                bus.dd_d_oe <= 1'b0;
                st_q        <= D_DONE;
            end
            D_DONE: if (!ack_act) begin
                busy <= 1'b0;
                st_q <= D_IDLE;
            end
            default: st_q <= D_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receive side: capture and pause
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_data   <= '0;
            rx_valid  <= 1'b0;
            bus.drdy_n <= 1'b1;
            rdy_neg_q <= 1'b0;
            rdy_tmr_q <= '0;
        end else begin
            rx_valid <= 1'b0;
            if (st_q == D_RECV && hstb_edge) begin
                rx_data  <= dd_s2;
                rx_valid <= 1'b1;
            end
            if (rdy_tmr_q != '0) rdy_tmr_q <= rdy_tmr_q - 1'b1;
            bus.drdy_n <= !(st_q == D_RECV && !rx_pause);
            if (st_q == D_RECV && rx_pause && !rdy_neg_q) begin
                rdy_neg_q <= 1'b1;
                rdy_tmr_q <= udb_min(T_RP_NS[udb_idx(mode_q)]);
            end else if (!rx_pause) rdy_neg_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Error register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) err_reg <= 8'h00;
        else if (st_q == D_IDLE && start) err_reg <= 8'h00;
        else if (crc_bad) err_reg[ERR_CRC_BIT] <= 1'b1;
    end
endmodule

// >>> rtl/udb_host.sv
`timescale 1ns/1ps
module udb_host
    import udb_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    udb_if.host                    bus,
    input  wire udb_mode_t         mode,
    input  wire logic              dir_in,
    input  wire logic [DATA_W-1:0] tx_data,
    input  wire logic              tx_valid,
    output logic                   tx_ready,
    output logic [DATA_W-1:0]      rx_data,
    output logic                   rx_valid,
    input  wire logic              rx_pause,
    input  wire logic              halt,
    output logic                   busy
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_SET  = 3'b001,
        H_XFER = 3'b010,
        H_STOP = 3'b011,
        H_HOLD = 3'b100
    } udb_hst_e;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rq_s, dstb_s, drdy_s;
    logic       dstb_q;
    logic [DATA_W-1:0] dd_s1, dd_s2;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rq_s   <= 2'h0;
            dstb_s <= 2'h0;
            drdy_s <= 2'h3;
            dstb_q <= 1'b0;
            dd_s1  <= '0;
            dd_s2  <= '0;
        end else begin
            rq_s   <= {rq_s[0], bus.dmarq};
            dstb_s <= {dstb_s[0], bus.dstrobe};
            drdy_s <= {drdy_s[0], bus.drdy_n};
            dstb_q <= dstb_s[1];
            dd_s1  <= bus.dd_d;
            dd_s2  <= dd_s1;
        end
    end
    wire dstb_edge = dstb_s[1] ^ dstb_q;

    udb_hst_e         st_q;
    logic [CNT_W-1:0] tmr_q;
    logic             out_q;
    udb_mode_t        mode_q;

    // ------------------------------------------------------------
    // Burst sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q   <= H_IDLE;
            tmr_q  <= '0;
            out_q  <= 1'b0;
            mode_q <= UDB_MODE0;
            bus.dmack_n <= 1'b1;
            bus.stop    <= 1'b0;
            bus.hstrobe <= 1'b0;
            bus.hrdy_n  <= 1'b1;
            bus.dd_h    <= '0;
            bus.dd_h_oe <= 1'b0;
            tx_ready <= 1'b0;
            rx_data  <= '0;
            rx_valid <= 1'b0;
            busy     <= 1'b0;
        end else begin
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            if (tmr_q != '0) tmr_q <= tmr_q - 1'b1;
            case (st_q)
            H_IDLE: if (rq_s[1]) begin
                mode_q <= (mode > UDB_MODE2) ? UDB_MODE2 : mode;
                out_q  <= !dir_in;
                tmr_q  <= C_ACK;
                busy   <= 1'b1;
                st_q   <= H_SET;
            end
            H_SET: if (tmr_q == '0) begin
                bus.dmack_n <= 1'b0;
                bus.dd_h_oe <= out_q;
                bus.dd_h    <= tx_data;
                bus.hrdy_n  <= out_q;
                tmr_q <= C_ENV;
                st_q  <= H_XFER;
            end
            H_XFER: begin
                if (!out_q && dstb_edge) begin
                    rx_data  <= dd_s2;
                    rx_valid <= 1'b1;
                end
                if (!out_q) bus.hrdy_n <= rx_pause;
                if (out_q && tmr_q == '0 && tx_valid && !drdy_s[1]) begin
                    bus.hstrobe <= !bus.hstrobe;
                    bus.dd_h    <= tx_data;
                    tx_ready    <= 1'b1;
                    tmr_q <= udb_half(mode_q);
                end
                if (halt || !rq_s[1]) begin
                    tmr_q <= C_SS;
                    st_q  <= H_STOP;
                end
            end
            H_STOP: if (tmr_q == '0) begin
                bus.stop <= 1'b1;
                if (!rq_s[1]) begin
                    tmr_q <= C_ACK;
                    st_q  <= H_HOLD;
                end
            end
            H_HOLD: if (tmr_q == '0) begin
                bus.dmack_n <= 1'b1;
                bus.stop    <= 1'b0;
                bus.dd_h_oe <= 1'b0;
                bus.hrdy_n  <= 1'b1;
                busy <= 1'b0;
                st_q <= H_IDLE;
            end
            default: st_q <= H_IDLE;
            endcase
        end
    end
endmodule

// >>> rtl/udb_if.sv
`timescale 1ns/1ps
interface udb_if;
    logic        dmarq;
    logic        dmack_n;
    logic        stop;
    logic        hstrobe;
    logic        dstrobe;
    logic        hrdy_n;
    logic        drdy_n;
    logic [15:0] dd_h;
    logic        dd_h_oe;
    logic [15:0] dd_d;
    logic        dd_d_oe;

    modport dev (input dmack_n, stop, hstrobe, hrdy_n, dd_h, dd_h_oe,
                 output dmarq, dstrobe, drdy_n, dd_d, dd_d_oe);
    modport host (input dmarq, dstrobe, drdy_n, dd_d, dd_d_oe,
                  output dmack_n, stop, hstrobe, hrdy_n, dd_h, dd_h_oe);
endinterface

// >>> rtl/udb_pkg.sv
package udb_pkg;
    // ------------------------------------------------------------
    // Clock and widths
    // ------------------------------------------------------------
    localparam int CLK_PS   = 5000;
    localparam int DATA_W   = 16;
    localparam int CNT_W    = 8;
    localparam int ERR_CRC_BIT = 7;

    typedef logic [1:0] udb_mode_t;
    localparam udb_mode_t UDB_MODE0 = 2'h0;
    localparam udb_mode_t UDB_MODE1 = 2'h1;
    localparam udb_mode_t UDB_MODE2 = 2'h2;

    // ------------------------------------------------------------
    // Timing figures in ns, per mode 0 / 1 / 2
    // ------------------------------------------------------------
    localparam int T_CYC_NS [3]  = '{114, 75, 55};
    localparam int T_2CYC_NS[3]  = '{235, 156, 117};
    localparam int T_FS_NS  [3]  = '{230, 200, 170};
    localparam int T_SR_NS  [3]  = '{50, 30, 20};
    localparam int T_RFS_NS [3]  = '{75, 60, 50};
    localparam int T_RP_NS  [3]  = '{160, 125, 100};
    localparam int T_LI_NS       = 150;
    localparam int T_MLI_NS      = 20;
    localparam int T_ENV_MIN_NS  = 20;
    localparam int T_ENV_MAX_NS  = 70;
    localparam int T_ACK_NS      = 20;
    localparam int T_SS_NS       = 50;
    // Strobe sampling adds up to three clocks of latency
    localparam int SYNC_CYC      = 3;

    // Least time: round up; longest time: round down, floor one cycle
    function automatic logic [CNT_W-1:0] udb_min(input int ns);
        int c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        if (c < 1) c = 1;
        return CNT_W'(c);
    endfunction

    function automatic logic [CNT_W-1:0] udb_max(input int ns);
        int c;
        c = (ns * 1000) / CLK_PS;
        if (c < 1) c = 1;
        return CNT_W'(c);
    endfunction

    function automatic int udb_idx(input udb_mode_t m);
        return (m > UDB_MODE2) ? 2 : int'(m);
    endfunction

    // Strobe half period: larger of tCYC and half of t2CYC
    function automatic logic [CNT_W-1:0] udb_half(input udb_mode_t m);
        logic [CNT_W-1:0] a;
        logic [CNT_W-1:0] b;
        a = udb_min(T_CYC_NS[udb_idx(m)]);
        b = udb_min((T_2CYC_NS[udb_idx(m)] + 1) / 2);
        return (a > b) ? a : b;
    endfunction

    localparam logic [CNT_W-1:0] C_MLI = CNT_W'((T_MLI_NS*1000
                                         + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] C_ENV = CNT_W'((T_ENV_MIN_NS*1000
                                         + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] C_ACK = CNT_W'((T_ACK_NS*1000
                                         + CLK_PS - 1) / CLK_PS);
    localparam logic [CNT_W-1:0] C_SS  = CNT_W'((T_SS_NS*1000
                                         + CLK_PS - 1) / CLK_PS);
endpackage

// >>> test/tb.sv
`timescale 1ns/1ps
module tb
    import udb_pkg::*;
;
    typedef struct {udb_mode_t m; logic dir; int n; logic pz;
                    logic [7:0] e;} udb_row_s;

    logic        clk, rstn, start, crc_bad, halt, dir_in;
    udb_mode_t   mode;
    logic [15:0] d_txd, h_txd, d_rxd, h_rxd;
    logic        d_txv, h_txv, d_txr, h_txr, d_rxv, h_rxv;
    logic        d_pause, h_pause, d_busy, h_busy;
    logic [7:0]  err_reg;
    int          error_cnt, checks, k;
    logic [15:0] rxq[$];
    udb_row_s    rows[8] = '{'{0,1,4,0,0}, '{1,1,3,0,0}, '{2,1,1,0,0},
        '{0,0,4,0,0}, '{1,0,3,0,0}, '{2,0,5,1,0}, '{2,1,5,1,0},
        '{3,1,3,0,0}};

    udb_if bus_if();
    udb_dev udb_dev_inst(.clk(clk), .rstn(rstn), .bus(bus_if.dev),
        .mode(mode), .dir_in(dir_in), .start(start), .tx_data(d_txd),
        .tx_valid(d_txv), .tx_ready(d_txr), .rx_data(d_rxd),
        .rx_valid(d_rxv), .rx_pause(d_pause), .crc_bad(crc_bad),
        .err_reg(err_reg), .busy(d_busy));
    udb_host udb_host_inst(.clk(clk), .rstn(rstn), .bus(bus_if.host),
        .mode(mode), .dir_in(dir_in), .tx_data(h_txd), .tx_valid(h_txv),
        .tx_ready(h_txr), .rx_data(h_rxd), .rx_valid(h_rxv),
        .rx_pause(h_pause), .halt(halt), .busy(h_busy));
    udb_props udb_props_inst(.clk(clk), .rstn(rstn), .mode(mode),
        .dmarq(bus_if.dmarq), .dmack_n(bus_if.dmack_n), .stop(bus_if.stop),
        .hstrobe(bus_if.hstrobe), .dstrobe(bus_if.dstrobe),
        .drdy_n(bus_if.drdy_n), .dd_d_oe(bus_if.dd_d_oe));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (d_rxv === 1'b1) rxq.push_back(d_rxd);
        if (h_rxv === 1'b1) rxq.push_back(h_rxd);
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Receiver pauses mid-burst when the row asks; words must still arrive
    task automatic burst(input udb_row_s r, input logic [15:0] b);
        int i;
        int c;
        i = 0;
        @(posedge clk);
        mode <= r.m;
        dir_in <= r.dir;
        d_txd <= b;
        h_txd <= b;
        d_txv <= r.dir;
        h_txv <= !r.dir;
        @(posedge clk);
        rxq.delete();
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (c = 0; c < 4000 && (d_busy || h_busy || c < 4); c++) begin
            @(posedge clk);
            if ((r.dir ? d_txr : h_txr) === 1'b1 && i < r.n) begin
                i++;
                d_txd <= b + 16'(i);
                h_txd <= b + 16'(i);
                if (i == r.n) begin
                    d_txv <= 1'b0;
                    h_txv <= 1'b0;
                    halt <= !r.dir;
                end
            end
            d_pause <= r.pz && !r.dir && c >= 40 && c < 100;
            h_pause <= r.pz && r.dir && c >= 40 && c < 100;
        end
        halt <= 1'b0;
        repeat (4) @(posedge clk);
        chk(16'(c >= 4000), 16'h0000);
        chk(16'(rxq.size()), 16'(r.n));
        for (i = 0; i < r.n && i < rxq.size(); i++)
            chk(rxq[i], b + 16'(i));
        chk(16'(err_reg), 16'(r.e));
        $display("burst mode=%0d dir=%0d done", r.m, r.dir);
    endtask

    initial begin
        #200000;
        error_cnt++;
        conclude();
    end

    initial begin
        {rstn, start, crc_bad, halt, dir_in, d_txv, h_txv} = 7'h00;
        {d_pause, h_pause} = 2'h0;
        mode = 2'h0;
        d_txd = 16'h0000;
        h_txd = 16'h0000;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        for (k = 0; k < 8; k++)
            burst(rows[k], 16'hA5A0 + 16'(k) * 16'h1357);
        @(posedge clk);
        crc_bad <= 1'b1;
        @(posedge clk);
        crc_bad <= 1'b0;
        repeat (2) @(posedge clk);
        chk(16'(err_reg), 16'h0080);
        burst(rows[2], 16'h5AF0);
        $display("checksum flag test done");
        @(posedge clk);
        dir_in <= 1'b1;
        d_txv <= 1'b1;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (30) @(posedge clk);
        rstn <= 1'b0;
        d_txv <= 1'b0;
        repeat (2) @(posedge clk);
        chk(16'({bus_if.dmarq, bus_if.dmack_n, bus_if.stop, bus_if.dd_d_oe,
                 bus_if.dd_h_oe, d_busy, h_busy}), 16'h0020);
        rstn <= 1'b1;
        burst(rows[3], 16'h3C00);
        $display("mid-run reset test done");
        conclude();
    end
endmodule

// >>> test/udb_props.sv
`timescale 1ns/1ps
module udb_props
    import udb_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rstn,
    input  wire udb_mode_t mode,
    input  wire logic      dmarq,
    input  wire logic      dmack_n,
    input  wire logic      stop,
    input  wire logic      hstrobe,
    input  wire logic      dstrobe,
    input  wire logic      drdy_n,
    input  wire logic      dd_d_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // Mode figures in clocks; codes above 2 behave as mode 2
    // ------------------------------------------------------------
    function automatic int half_c(input udb_mode_t m);
        return (m == 2'h0) ? 24 : (m == 2'h1) ? 16 : 12;
    endfunction
    function automatic int two_c(input udb_mode_t m);
        return (m == 2'h0) ? 47 : (m == 2'h1) ? 32 : 24;
    endfunction
    function automatic int rfs_c(input udb_mode_t m);
        return (m == 2'h0) ? 15 : (m == 2'h1) ? 12 : 10;
    endfunction

    // ------------------------------------------------------------
    // Gap counters; saturate so idle gaps never wrap to small values
    // ------------------------------------------------------------
    logic [7:0] gd_q;
    logic [7:0] pd_q;
    logic [7:0] gh_q;
    logic [7:0] rn_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gd_q <= 8'hFF;
            pd_q <= 8'hFF;
        end else if ($changed(dstrobe)) begin
            gd_q <= 8'h01;
            pd_q <= gd_q;
        end else if (gd_q != 8'hFF) begin
            gd_q <= gd_q + 8'h01;
        end
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) gh_q <= 8'hFF;
        else if ($changed(hstrobe)) gh_q <= 8'h01;
        else if (gh_q != 8'hFF) gh_q <= gh_q + 8'h01;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) rn_q <= 8'h00;
        else if (!drdy_n || dmack_n) rn_q <= 8'h00;
        else if (rn_q != 8'hFF) rn_q <= rn_q + 8'h01;
    end

    sequence s_quiet;
        ($stable(dstrobe) && $stable(hstrobe) && $stable(stop))[*4];
    endsequence
    sequence s_first;
        $stable(dstrobe)[*4] ##[1:30] $changed(dstrobe);
    endsequence

    property p_dgap;  $changed(dstrobe) |-> gd_q >= half_c(mode); endproperty
    property p_hgap;  $changed(hstrobe) |-> gh_q >= half_c(mode); endproperty
    property p_two;
        $changed(dstrobe) |-> int'(pd_q) + int'(gd_q) >= two_c(mode);
    endproperty
    property p_first; $rose(dd_d_oe) |-> s_first; endproperty
    property p_li;    $fell(dmarq) && !dmack_n |-> ##[0:30] stop; endproperty
    property p_env;   $fell(dmack_n) |-> s_quiet; endproperty
    property p_rfs;
        $changed(hstrobe) |-> !(drdy_n && rn_q > rfs_c(mode));
    endproperty
    property p_ack;   $rose(dmack_n) |-> $past(stop, 3) && $past(stop); endproperty
    property p_ss;    $rose(stop) |-> gh_q >= 8'h0A; endproperty
    property p_rq;    $fell(dmack_n) |-> dmarq; endproperty

    a_dgap:  assert property (p_dgap)  else $error("dstrobe gap short");
    a_hgap:  assert property (p_hgap)  else $error("hstrobe gap short");
    a_two:   assert property (p_two)   else $error("two cycle short");
    a_first: assert property (p_first) else $error("first strobe");
    a_li:    assert property (p_li)    else $error("stop too late");
    a_env:   assert property (p_env)   else $error("envelope broken");
    a_rfs:   assert property (p_rfs)   else $error("strobe after cutoff");
    a_ack:   assert property (p_ack)   else $error("ack hold short");
    a_ss:    assert property (p_ss)    else $error("stop too soon");
    a_rq:    assert property (p_rq)    else $error("ack without req");
endmodule
